// ===== logic/aims_pin.sv
/*
  Per-pin source resolution: applies digital-mode grounding and missing
  pins to one routed source code. Combinational; assumes fixed variant.
*/
module aims_pin #(
  parameter bit LARGE = 1'b1
) (
  input wire logic [3:0] src,
  input wire logic [9:0] pin_mode,
  input wire logic scan,
  output logic [3:0] eff
);

  function automatic logic present(input logic [3:0] n);
    present = LARGE ? (n <= 4'h9) : (n <= 4'h3 || n == 4'h6 || n == 4'h7);
  endfunction

  always_comb
  begin
    eff = src;
    if (src <= 4'h9)
    begin
      if (!present(src))
        eff = scan ? aims_pkg::SRC_CONV_REF : aims_pkg::SRC_NC; // (R11) (R13)
      else if (pin_mode[src])
        eff = aims_pkg::SRC_GND; // (R12)
    end
  end

endmodule

// ===== logic/aims_pkg.sv
/*
  Package for the converter input multiplexer select block: register map,
  field positions, reset values, routing codes and shared carrier structs.
  Assumes a 32-bit Avalon-MM slave with word addressing in byte units.
*/
package aims_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CH123 = 4'h0;
  localparam logic [3:0] OFS_CH0 = 4'h4;
  localparam logic [3:0] OFS_SCAN = 4'h8;
  localparam logic [3:0] OFS_PIN_MODE = 4'hC;
  localparam logic [3:0] OFS_CTRL = 4'h0;

  // Writable masks, unimplemented bits read as zero
  localparam logic [15:0] MASK_CH123 = 16'h0707;
  localparam logic [15:0] MASK_CH0 = 16'h9F9F;
  localparam logic [15:0] MASK_SCAN = 16'h03FF;
  localparam logic [15:0] MASK_PIN_MODE = 16'h03FF;
  localparam logic [15:0] MASK_CTRL = 16'h0007;
  localparam logic [15:0] RESET_VAL = 16'h0000;

  // Field positions
  localparam int POS_NEG_B = 9;
  localparam int POS_POS_B = 8;
  localparam int POS_NEG_A = 1;
  localparam int POS_POS_A = 0;
  localparam int POS_CH0N_B = 15;
  localparam int POS_CH0S_B = 8;
  localparam int POS_CH0N_A = 7;
  localparam int POS_CH0S_A = 0;
  localparam int POS_RES = 0;
  localparam int POS_CNT = 1;

  localparam int NUM_INPUTS = 10;

  // Mux routing codes: 0-9 analog input, others special
  localparam logic [3:0] SRC_REF_NEG = 4'hA;
  localparam logic [3:0] SRC_NC = 4'hB;
  localparam logic [3:0] SRC_RSVD = 4'hC;
  localparam logic [3:0] SRC_CONV_REF = 4'hD;
  localparam logic [3:0] SRC_GND = 4'hE;

  // Channel counts
  localparam logic [1:0] CNT_ONE = 2'h0;
  localparam logic [1:0] CNT_TWO = 2'h1;

  typedef struct packed {
    logic [3:0] ch0_pos;
    logic [3:0] ch0_neg;
    logic [3:0] ch1_pos;
    logic [3:0] ch1_neg;
    logic [3:0] ch2_pos;
    logic [3:0] ch2_neg;
    logic [3:0] ch3_pos;
    logic [3:0] ch3_neg;
  } aims_route_t;

  typedef struct packed {
    logic [1:0] ch123_neg;
    logic ch123_pos;
    logic ch0_neg;
    logic [4:0] ch0_pos;
  } aims_set_t;

endpackage

// ===== logic/aims_route.sv
/*
  Combinational decoder from one sample set's select fields to the
  routing of all four channels. Assumes the variant is fixed at build.
*/
module aims_route #(
  parameter bit LARGE = 1'b1
) (
  input wire aims_pkg::aims_set_t sel,
  input wire logic res12,
  input wire logic [1:0] chan_cnt,
  output aims_pkg::aims_route_t route
);

  function automatic logic [3:0] ch0_dec(input logic [4:0] code);
    if (LARGE)
      ch0_dec = (code <= 5'h09) ? code[3:0] : aims_pkg::SRC_RSVD; // (R9)
    else if (code <= 5'h03 || code == 5'h06 || code == 5'h07)
      ch0_dec = code[3:0]; // (R8)
    else
      ch0_dec = aims_pkg::SRC_RSVD; // (R8)
  endfunction

  always_comb
  begin
    route = '{default: aims_pkg::SRC_NC};
    route.ch0_pos = ch0_dec(sel.ch0_pos); // (R17)
    route.ch0_neg = sel.ch0_neg ? 4'h1 : aims_pkg::SRC_REF_NEG; // (R7)
    if (res12)
    begin
      route.ch1_pos = aims_pkg::SRC_RSVD; // (R3)
      route.ch1_neg = aims_pkg::SRC_RSVD;
      route.ch2_pos = aims_pkg::SRC_RSVD;
      route.ch2_neg = aims_pkg::SRC_RSVD;
      route.ch3_pos = aims_pkg::SRC_RSVD;
      route.ch3_neg = aims_pkg::SRC_RSVD;
    end
    else
    begin
      if (sel.ch123_pos)
      begin
        route.ch1_pos = 4'h3; // (R4) (R5)
        route.ch2_pos = LARGE ? 4'h4 : aims_pkg::SRC_NC; // (R4) (R5)
        route.ch3_pos = LARGE ? 4'h5 : aims_pkg::SRC_NC;
      end
      else
      begin
        route.ch1_pos = 4'h0; // (R4)
        route.ch2_pos = 4'h1;
        route.ch3_pos = 4'h2;
      end
      case (sel.ch123_neg)
        2'h3:
        begin
          route.ch1_neg = LARGE ? 4'h9 : aims_pkg::SRC_RSVD; // (R1) (R2)
          route.ch2_neg = LARGE ? aims_pkg::SRC_NC : aims_pkg::SRC_RSVD;
          route.ch3_neg = LARGE ? aims_pkg::SRC_NC : aims_pkg::SRC_RSVD;
        end
        2'h2:
        begin
          route.ch1_neg = 4'h6; // (R1) (R2)
          route.ch2_neg = 4'h7;
          route.ch3_neg = LARGE ? 4'h8 : aims_pkg::SRC_NC;
        end
        default:
        begin
          route.ch1_neg = aims_pkg::SRC_REF_NEG; // (R1)
          route.ch2_neg = aims_pkg::SRC_REF_NEG;
          route.ch3_neg = aims_pkg::SRC_REF_NEG;
        end
      endcase
    end
    // Unconverted channels disconnected
    if (chan_cnt == aims_pkg::CNT_ONE || res12)
    begin
      route.ch1_pos = aims_pkg::SRC_NC; // (R16)
      route.ch1_neg = aims_pkg::SRC_NC;
    end
    if (chan_cnt[1] == 1'b0 || res12)
    begin
      route.ch2_pos = aims_pkg::SRC_NC; // (R16)
      route.ch2_neg = aims_pkg::SRC_NC;
      route.ch3_pos = aims_pkg::SRC_NC;
      route.ch3_neg = aims_pkg::SRC_NC;
    end
  end

endmodule

// ===== logic/aims_top.sv
/*
  Converter input multiplexer select block: four select registers,
  scan stepping and resolved routing outputs.
  Assumes an Avalon-MM master and a converter that pulses sample steps.
*/
// Summary of operation
// (R1) Large variant 10-bit negative: 11 input 9 only, 10 inputs 6-8, else reference.
// (R2) Small variant 10-bit negative: 10 gives inputs 6, 7, none; 11 reserved.
// (R3) In 12-bit mode all channel 1-3 select codes are reserved.
// (R4) Large variant positive bit 1 routes inputs 3-5, 0 routes inputs 0-2.
// (R5) Small variant positive bit 1 routes input 3 to channel 1 only.
// (R6) Sample A holds its own channel 1-3 fields with the same decoding.
// (R7) Channel 0 negative bit 0 gives reference, 1 gives input 1.
// (R8) Small variant channel 0 positive: 0-3, 6, 7 valid; 4, 5 reserved.
// (R9) Large variant channel 0 positive codes 0-9 map to inputs 0-9.
// (R10) Each scan bit set includes its input in the scan sequence.
// (R11) Small variant scan bits writable; missing pins convert the reference.
// (R12) Port bit 1 digital and grounded mux input, 0 analog sampling.
// (R13) Small variant port bits writable; missing pins ignored.
// (R14) Unimplemented register bits read zero and ignore writes.
// (R15) Scan enable steps channel 0 positive through scanned inputs in Sample A.
// (R16) Channel count selects channels 0, 0-1, or 0-3 in use.
// (R17) Sample B channel 0 positive field at bits 12-8 decodes like Sample A.
module aims_top #(
  parameter bit LARGE = 1'b1
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RESOLUTION_MODE_SELECT,
  input wire logic [1:0] CHANNEL_COUNT_SELECT,
  input wire logic SCAN_ENABLE,
  input wire logic SAMPLE_B_SEL,
  input wire logic SCAN_STEP,
  output aims_pkg::aims_route_t ROUTE,
  output logic [9:0] DIGITAL_READ_EN,
  output logic [3:0] SCAN_INDEX
);

  typedef enum logic [1:0] {
    AIMS_IDLE = 2'b00,
    AIMS_ACK = 2'b01
  } aims_bus_t;

  aims_bus_t bus_reg;
  logic [15:0] ch123_reg;
  logic [15:0] ch0_reg;
  logic [15:0] scan_reg;
  logic [15:0] pin_mode_reg;
  logic [3:0] scan_idx_reg;
  logic [3:0] scan_idx_next;
  logic [15:0] wr_mask;
  logic [15:0] rd_val;
  logic req;
  logic scan_act;
  // Pins that exist on this variant
  localparam logic [9:0] PIN_MASK = LARGE ? 10'h3FF : 10'h0CF;
  aims_pkg::aims_set_t set_a;
  aims_pkg::aims_set_t set_b;
  aims_pkg::aims_set_t set_cur;
  aims_pkg::aims_route_t raw;
  aims_pkg::aims_route_t eff;

  assign req = (AVS_READ || AVS_WRITE) && bus_reg == AIMS_IDLE;
  assign wr_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign scan_act = SCAN_ENABLE && scan_reg[9:0] != 10'h000;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [15:0] be, input logic [15:0] m);
    merge = ((old & ~be) | (d & be)) & m; // (R14)
  endfunction

  // One wait cycle per access, answer in the second cycle
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      bus_reg <= AIMS_IDLE;
    else if (req)
      bus_reg <= AIMS_ACK;
    else
      bus_reg <= AIMS_IDLE;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !req;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ch123_reg <= aims_pkg::RESET_VAL;
      ch0_reg <= aims_pkg::RESET_VAL;
      scan_reg <= aims_pkg::RESET_VAL;
      pin_mode_reg <= aims_pkg::RESET_VAL;
    end
    else if (bus_reg == AIMS_ACK && AVS_WRITE)
    begin
      case (AVS_ADDRESS)
        aims_pkg::OFS_CH123:
          ch123_reg <= merge(ch123_reg, AVS_WRITEDATA[15:0], wr_mask,
                             aims_pkg::MASK_CH123); // (R6) (R14)
        aims_pkg::OFS_CH0:
          ch0_reg <= merge(ch0_reg, AVS_WRITEDATA[15:0], wr_mask, aims_pkg::MASK_CH0);
        aims_pkg::OFS_SCAN:
          scan_reg <= merge(scan_reg, AVS_WRITEDATA[15:0], wr_mask,
                            aims_pkg::MASK_SCAN); // (R11)
        aims_pkg::OFS_PIN_MODE:
          pin_mode_reg <= merge(pin_mode_reg, AVS_WRITEDATA[15:0], wr_mask,
                                aims_pkg::MASK_PIN_MODE); // (R13)
        default:
          ;
      endcase
    end
  end

  always_comb
  begin
    case (AVS_ADDRESS)
      aims_pkg::OFS_CH123: rd_val = ch123_reg;
      aims_pkg::OFS_CH0: rd_val = ch0_reg;
      aims_pkg::OFS_SCAN: rd_val = scan_reg;
      aims_pkg::OFS_PIN_MODE: rd_val = pin_mode_reg;
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      AVS_READDATA <= 32'h0000_0000;
    else if (req && AVS_READ)
      AVS_READDATA <= {16'h0000, rd_val}; // (R14)
  end

  // Next scan-selected input after the current one, wrapping
  always_comb
  begin
    scan_idx_next = scan_idx_reg;
    for (int k = 10; k >= 1; k--)
    begin
      if (scan_reg[(32'(scan_idx_reg) + k) % 10])
        scan_idx_next = 4'((32'(scan_idx_reg) + k) % 10); // (R10)
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      scan_idx_reg <= 4'h0;
    else if (!scan_act)
      scan_idx_reg <= 4'h0;
    else if (SCAN_STEP)
      scan_idx_reg <= scan_idx_next; // (R15)
  end

  always_comb
  begin
    set_a.ch123_neg = ch123_reg[aims_pkg::POS_NEG_A +: 2]; // (R6)
    set_a.ch123_pos = ch123_reg[aims_pkg::POS_POS_A];
    set_a.ch0_neg = ch0_reg[aims_pkg::POS_CH0N_A];
    set_a.ch0_pos = ch0_reg[aims_pkg::POS_CH0S_A +: 5];
    if (scan_act)
      set_a.ch0_pos = {1'b0, scan_idx_reg}; // (R15)
    set_b.ch123_neg = ch123_reg[aims_pkg::POS_NEG_B +: 2];
    set_b.ch123_pos = ch123_reg[aims_pkg::POS_POS_B];
    set_b.ch0_neg = ch0_reg[aims_pkg::POS_CH0N_B];
    set_b.ch0_pos = ch0_reg[aims_pkg::POS_CH0S_B +: 5]; // (R17)
    set_cur = SAMPLE_B_SEL ? set_b : set_a;
  end

  aims_route #(
    .LARGE(LARGE)
  ) u_route (
    .sel(set_cur),
    .res12(RESOLUTION_MODE_SELECT),
    .chan_cnt(CHANNEL_COUNT_SELECT),
    .route(raw)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_pin
      aims_pin #(
        .LARGE(LARGE)
      ) u_pin (
        .src(raw[g*4 +: 4]),
        .pin_mode(pin_mode_reg[9:0]),
        .scan(g == 7 && scan_act && !SAMPLE_B_SEL),
        .eff(eff[g*4 +: 4])
      );
    end
  endgenerate

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ROUTE <= '{default: aims_pkg::SRC_NC};
      DIGITAL_READ_EN <= 10'h000;
      SCAN_INDEX <= 4'h0;
    end
    else
    begin
      ROUTE <= eff;
      DIGITAL_READ_EN <= pin_mode_reg[9:0] & PIN_MASK; // (R12) (R13)
      SCAN_INDEX <= scan_idx_reg;
    end
  end

  AST_WAIT_ONE: assert property (@(posedge CLK) disable iff (!RESET_N) // (R14)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Access not answered in one cycle");
  AST_RD_ZERO: assert property (@(posedge CLK) disable iff (!RESET_N) // (R14)
    !AVS_WAITREQUEST && $past(AVS_READ) |-> AVS_READDATA[31:16] == 16'h0 &&
    (AVS_READDATA[15:10] == 6'h0 || $past(AVS_ADDRESS) == aims_pkg::OFS_CH0 ||
    $past(AVS_ADDRESS) == aims_pkg::OFS_CH123))
    else $error("Unimplemented bits read nonzero");
  AST_MASK: assert property (@(posedge CLK) disable iff (!RESET_N) // (R14)
    (ch123_reg & ~aims_pkg::MASK_CH123) == 16'h0 &&
    (ch0_reg & ~aims_pkg::MASK_CH0) == 16'h0)
    else $error("Reserved select bits stored");
  AST_GND: assert property (@(posedge CLK) disable iff (!RESET_N) // (R12)
    LARGE && raw.ch0_pos <= 4'h9 && pin_mode_reg[raw.ch0_pos]
    |=> ROUTE.ch0_pos == aims_pkg::SRC_GND)
    else $error("Digital pin routed to converter");
  AST_NEG0: assert property (@(posedge CLK) disable iff (!RESET_N) // (R7)
    !set_cur.ch0_neg |=> ROUTE.ch0_neg == aims_pkg::SRC_REF_NEG)
    else $error("Channel 0 negative not reference");
  AST_RES12: assert property (@(posedge CLK) disable iff (!RESET_N) // (R3)
    RESOLUTION_MODE_SELECT |=> ROUTE.ch1_pos == aims_pkg::SRC_NC &&
    ROUTE.ch3_neg == aims_pkg::SRC_NC)
    else $error("Channels 1-3 routed in 12-bit mode");
  AST_ONE_CH: assert property (@(posedge CLK) disable iff (!RESET_N) // (R16)
    CHANNEL_COUNT_SELECT == aims_pkg::CNT_ONE |=> ROUTE.ch1_neg == aims_pkg::SRC_NC)
    else $error("Channel 1 routed with one channel");
  AST_SCAN_SEL: assert property (@(posedge CLK) disable iff (!RESET_N) // (R10)
    scan_act && $past(SCAN_ENABLE) && $past(SCAN_STEP)
    |-> scan_reg[scan_idx_reg])
    else $error("Scan stepped to skipped input");
  AST_SCAN_A: assert property (@(posedge CLK) disable iff (!RESET_N) // (R15)
    scan_act && !SAMPLE_B_SEL && LARGE && !pin_mode_reg[scan_idx_reg]
    |=> ROUTE.ch0_pos == $past(scan_idx_reg))
    else $error("Sample A ignores scan");
  AST_POS_B: assert property (@(posedge CLK) disable iff (!RESET_N) // (R17)
    SAMPLE_B_SEL |-> set_cur.ch0_pos == ch0_reg[12:8])
    else $error("Sample B channel 0 field wrong");

endmodule

// ===== tb/testbench.sv
/*
  Self-checking bench for the converter input select block, large variant.
  Assumes the block answers Avalon-MM requests and registers its routing.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int k; logic [31:0] v;} aims_note_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wait_r;
  logic res12 = 1'b0;
  logic [1:0] chn_cnt = 2'h2;
  logic scan_en = 1'b0;
  logic smp_b = 1'b0;
  logic step = 1'b0;
  logic chk_go = 1'b0;
  aims_pkg::aims_route_t route;
  logic [9:0] dig_en;
  logic [3:0] scan_idx;
  logic [31:0] lfsr = 32'h779951DA;
  logic [3:0] ofs[4] = '{aims_pkg::OFS_CH123, aims_pkg::OFS_CH0, aims_pkg::OFS_SCAN,
    aims_pkg::OFS_PIN_MODE};
  logic [15:0] msk[4] = '{aims_pkg::MASK_CH123, aims_pkg::MASK_CH0, aims_pkg::MASK_SCAN,
    aims_pkg::MASK_PIN_MODE};
  logic [3:0] idx_seq[4] = '{4'h0, 4'h4, 4'h9, 4'h0};
  string nm[4] = '{"readdata", "route", "scan_index", "digital_read_en"};
  aims_note_t q[$];
  aims_note_t nt;
  logic [31:0] seen;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  aims_top #(.LARGE(1'b1)) u_aims_top (.CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r), .RESOLUTION_MODE_SELECT(res12),
    .CHANNEL_COUNT_SELECT(chn_cnt), .SCAN_ENABLE(scan_en), .SAMPLE_B_SEL(smp_b),
    .SCAN_STEP(step), .ROUTE(route), .DIGITAL_READ_EN(dig_en), .SCAN_INDEX(scan_idx));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected routing with all pins analog and no scanning
  function automatic aims_pkg::aims_route_t exp_route(input logic [2:0] c, input logic n0,
      input logic [3:0] p0, input logic [1:0] cp, input logic r12);
    aims_pkg::aims_route_t r;
    r = {8{aims_pkg::SRC_NC}};
    r.ch0_pos = p0;
    r.ch0_neg = n0 ? 4'h1 : aims_pkg::SRC_REF_NEG;
    if (!r12 && cp != 2'h0)
    begin
      r.ch1_pos = c[0] ? 4'h3 : 4'h0;
      r.ch1_neg = (c[2:1] == 2'h3) ? 4'h9 : (c[2] ? 4'h6 : aims_pkg::SRC_REF_NEG);
      if (cp[1])
      begin
        r.ch2_pos = c[0] ? 4'h4 : 4'h1;
        r.ch3_pos = c[0] ? 4'h5 : 4'h2;
        r.ch2_neg = (c[2:1] == 2'h3) ? aims_pkg::SRC_NC : (c[2] ? 4'h7 : aims_pkg::SRC_REF_NEG);
        r.ch3_neg = (c[2:1] == 2'h3) ? aims_pkg::SRC_NC : (c[2] ? 4'h8 : aims_pkg::SRC_REF_NEG);
      end
    end
    return r;
  endfunction

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    be <= b;
    rd <= ~w;
    wr <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_r !== 1'b0 && n < 50);
    if (n >= 50)
      fails++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] v);
    q.push_back('{0, v});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // Output settles one register stage after its cause; two edges are allowed
  task automatic expect_out(input int k, input logic [31:0] v);
    q.push_back('{k, v});
    @(posedge clk);
    @(posedge clk);
    chk_go <= 1'b1;
    @(posedge clk);
    chk_go <= 1'b0;
  endtask

  task automatic complete_run;
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    if ((rd && !wait_r) || chk_go)
    begin
      if (q.size() == 0)
        nt = '{9, 32'h0};
      else
        nt = q.pop_front();
      case (nt.k)
        0: seen = rdat;
        1: seen = route;
        2: seen = {28'h0, scan_idx};
        default: seen = {22'h0, dig_en};
      endcase
      check_count++;
      if (nt.k > 3 || seen !== nt.v)
      begin
        fails++;
        $display("mismatch %s expected %h seen %h", nm[nt.k & 3], nt.v, seen);
      end
    end
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ofs[i])
      rd_chk(ofs[i], 32'h0);
    foreach (ofs[i])
    begin
      bus(1'b1, ofs[i], 32'hFFFFFFFF, 4'hF);
      rd_chk(ofs[i], {16'h0, msk[i]});
    end
    bus(1'b1, 4'h2, 32'h0, 4'hF);
    rd_chk(4'h2, 32'h0);
    rd_chk(aims_pkg::OFS_CH123, {16'h0, aims_pkg::MASK_CH123});
    bus(1'b1, aims_pkg::OFS_SCAN, 32'h0, 4'h1);
    rd_chk(aims_pkg::OFS_SCAN, 32'h300);
    repeat (4)
    begin
      lfsr = next_rand(lfsr);
      bus(1'b1, aims_pkg::OFS_PIN_MODE, lfsr, 4'hF);
      rd_chk(aims_pkg::OFS_PIN_MODE, {16'h0, lfsr[15:0] & aims_pkg::MASK_PIN_MODE});
      expect_out(3, {22'h0, lfsr[9:0]});
    end
    bus(1'b1, aims_pkg::OFS_PIN_MODE, 32'h0, 4'hF);
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, aims_pkg::OFS_CH123, {16'h0, 5'h0, 3'(7 - c), 5'h0, 3'(c)}, 4'hF);
      bus(1'b1, aims_pkg::OFS_CH0, {16'h0, ~c[0], 2'h0, 5'(c + 2), c[0], 2'h0, 5'(c)}, 4'hF);
      smp_b <= 1'b0;
      expect_out(1, exp_route(3'(c), c[0], 4'(c), chn_cnt, res12));
      smp_b <= 1'b1;
      expect_out(1, exp_route(3'(7 - c), ~c[0], 4'(c + 2), chn_cnt, res12));
    end
    for (int m = 0; m < 5; m++)
    begin
      chn_cnt <= (m == 4) ? 2'h2 : 2'(m);
      res12 <= (m == 4);
      expect_out(1, exp_route(3'h0, 1'b0, 4'h9, 2'(m), m == 4));
    end
    res12 <= 1'b0;
    chn_cnt <= 2'h2;
    bus(1'b1, aims_pkg::OFS_SCAN, 32'h211, 4'hF);
    smp_b <= 1'b0;
    scan_en <= 1'b1;
    foreach (idx_seq[i])
    begin
      if (i > 0)
      begin
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
      end
      expect_out(2, {28'h0, idx_seq[i]});
      expect_out(1, exp_route(3'h7, 1'b1, idx_seq[i], 2'h2, 1'b0));
    end
    bus(1'b1, aims_pkg::OFS_PIN_MODE, 32'h1, 4'hF);
    expect_out(3, 32'h1);
    expect_out(1, exp_route(3'h7, 1'b1, aims_pkg::SRC_GND, 2'h2, 1'b0));
    complete_run();
  end
endmodule
